// *** shared/tbc_pkg.sv ***
// Constants, types and helper functions for the six-channel timer block
package tbc_pkg;
	localparam int          NUM_CH      = 6;
	localparam int          CW          = 16;
	localparam int          MW          = 10;
	localparam logic [7:0]  ADR_START0  = 8'h00;
	localparam logic [7:0]  ADR_START1  = 8'h04;
	localparam logic [7:0]  ADR_PRESC   = 8'h08;
	localparam logic [7:0]  ADR_PINS    = 8'h0C;
	localparam logic [7:0]  ADR_CH_BASE = 8'h10;
	localparam logic [7:0]  CH_STRIDE   = 8'h08;
	localparam logic [7:0]  CH_CNT_OFS  = 8'h04;
	localparam int          MD_MODE_LSB = 0;
	localparam int          MD_SEL_LOW  = 2;
	localparam int          MD_SEL_HIGH = 3;
	localparam int          MD_OVF      = 4;
	localparam int          MD_EVT_SRC  = 5;
	localparam int          MD_CLK_LSB  = 6;
	localparam int          MD_EDGE_LSB = 8;
	localparam logic [9:0]  MODE_RST    = 10'h000;
	localparam logic [15:0] CNT_RST     = 16'h0000;
	localparam logic [15:0] CNT_ZERO    = 16'h0000;
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	localparam logic [3:0]  PRESC_RST   = 4'h0;
	localparam logic [2:0]  DIV8_LAST   = 3'h7;
	localparam logic [4:0]  DIV32_LAST  = 5'h1F;
	localparam logic [1:0]  CLK_F1      = 2'h0;
	localparam logic [1:0]  CLK_F8      = 2'h1;
	localparam logic [1:0]  CLK_F2N     = 2'h2;
	localparam logic [1:0]  CLK_SUBCLOCK_DIV32    = 2'h3;
	localparam logic [1:0]  EDGE_FALL   = 2'h0;
	localparam logic [1:0]  EDGE_RISE   = 2'h1;
	localparam logic [1:0]  EDGE_BOTH   = 2'h2;

	typedef enum logic [1:0] {
		TBC_MODE_INTERVAL = 2'h0,
		TBC_MODE_EVENT    = 2'h1,
		TBC_MODE_MEASURE  = 2'h2
	} tbc_mode_t;

	function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
		edge_hit = ((sel == EDGE_FALL) && fall) || ((sel == EDGE_RISE) && rise) ||
			((sel == EDGE_BOTH) && (rise || fall));
	endfunction : edge_hit

	function automatic int prev_ch(input int i);
		return (i == 0) ? 2 : ((i == 3) ? 5 : i - 1);
	endfunction : prev_ch

	function automatic logic [7:0] ch_md_adr(input int i);
		return 8'(int'(ADR_CH_BASE) + i * int'(CH_STRIDE));
	endfunction : ch_md_adr
endpackage : tbc_pkg

// *** shared/tbc_tick_if.sv ***
// Count-source tick enables shared by all timer channels
`timescale 1ns/10ps
interface tbc_tick_if;
	logic f1;
	logic f8;
	logic f2n;
	logic subclock_div32;
	modport src (output f1, output f8, output f2n, output subclock_div32);
	modport user (input f1, input f8, input f2n, input subclock_div32);
endinterface : tbc_tick_if

// *** src/tbc_clk_src.sv ***
// Shared prescaler producing the count-source tick enables
`timescale 1ns/10ps
module tbc_clk_src (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic [3:0] divide,
	input  wire logic       sub_tick,
	tbc_tick_if.src         ticks
);
	logic [2:0] div8_r;
	logic [4:0] div2n_r;
	logic [4:0] div32_r;
	logic [4:0] last2n;

	// Divide by 2n needs a terminal count of 2n-1
	assign last2n     = 5'({divide, 1'b0}) - 5'h01;
	assign ticks.f1   = 1'b1;
	assign ticks.f8   = (div8_r == tbc_pkg::DIV8_LAST);
	assign ticks.f2n  = (divide == tbc_pkg::PRESC_RST) || (div2n_r >= last2n);
	assign ticks.subclock_div32 = sub_tick && (div32_r == tbc_pkg::DIV32_LAST);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div8_r <= 3'h0;
		end else begin
			div8_r <= div8_r + 3'h1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div2n_r <= 5'h00;
		end else if (ticks.f2n) begin
			div2n_r <= 5'h00;
		end else begin
			div2n_r <= div2n_r + 5'h01;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div32_r <= 5'h00;
		end else if (sub_tick) begin
			div32_r <= div32_r + 5'h01;
		end
	end
endmodule : tbc_clk_src

// *** src/tbc_top.sv ***
// Six-channel 16-bit three-mode timer with a Wishbone register slave
`timescale 1ns/10ps
module tbc_top (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [5:0]  channel_input_pin,
	input  wire logic        fc_tick,
	output logic      [5:0]  irq_req
);
	tbc_tick_if tick_bus ();

	logic        ack_r;
	logic        bus_req;
	logic        wr_en;
	logic [31:0] dat_r;
	logic [31:0] rd_nxt;
	logic [5:0]  run_r;
	logic [3:0]  presc_r;
	logic [5:0]  pin_s1_r;
	logic [5:0]  pin_s2_r;
	logic [5:0]  pin_s3_r;
	logic [5:0]  rise;
	logic [5:0]  fall;
	logic [9:0]  mode_r  [6];
	logic        ovf_r   [6];
	logic        ovft_r  [6];
	logic [15:0] cnt_r   [6];
	logic [15:0] rel_r   [6];
	logic        uf_r    [6];
	logic        irq_r   [6];
	logic        first_r [6];

	function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] nv,
		input logic [3:0] sel);
		lane16 = {sel[1] ? nv[15:8] : old[15:8], sel[0] ? nv[7:0] : old[7:0]};
	endfunction : lane16

	tbc_clk_src u_clk_src (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.divide   (presc_r),
		.sub_tick (fc_tick),
		.ticks    (tick_bus)
	);

	// Write lands on the edge where the master sees ack, so it happens exactly once
	assign bus_req  = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr_en    = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dat_r <= 32'h0000_0000;
		end else if (bus_req) begin
			dat_r <= rd_nxt;
		end
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (wb_adr_i)
			tbc_pkg::ADR_START0: rd_nxt[2:0] = run_r[2:0];
			tbc_pkg::ADR_START1: rd_nxt[2:0] = run_r[5:3];
			tbc_pkg::ADR_PRESC:  rd_nxt[3:0] = presc_r;
			tbc_pkg::ADR_PINS:   rd_nxt[5:0] = pin_s2_r;
			default: begin
				for (int i = 0; i < tbc_pkg::NUM_CH; i++) begin
					if (wb_adr_i == tbc_pkg::ch_md_adr(i)) begin
						rd_nxt[9:0] = mode_r[i];
						rd_nxt[tbc_pkg::MD_OVF] = ovf_r[i];
					end
					if (wb_adr_i == tbc_pkg::ch_md_adr(i) + tbc_pkg::CH_CNT_OFS) begin
						rd_nxt[15:0] = (mode_r[i][1:0] == tbc_pkg::TBC_MODE_MEASURE) ?
							rel_r[i] : cnt_r[i];
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			run_r <= 6'h00;
		end else if (wr_en && wb_sel_i[0]) begin
			if (wb_adr_i == tbc_pkg::ADR_START0) begin
				run_r[2:0] <= wb_dat_i[2:0];
			end
			if (wb_adr_i == tbc_pkg::ADR_START1) begin
				run_r[5:3] <= wb_dat_i[2:0];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			presc_r <= tbc_pkg::PRESC_RST;
		end else if (wr_en && wb_sel_i[0] && wb_adr_i == tbc_pkg::ADR_PRESC) begin
			presc_r <= wb_dat_i[3:0];
		end
	end

	// The second and third stages feed edge detection; the first may be metastable
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin_s1_r <= 6'h00;
			pin_s2_r <= 6'h00;
			pin_s3_r <= 6'h00;
		end else begin
			pin_s1_r <= channel_input_pin;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	assign rise = pin_s2_r & ~pin_s3_r;
	assign fall = ~pin_s2_r & pin_s3_r;

	for (genvar g = 0; g < tbc_pkg::NUM_CH; g++) begin : g_ch
		localparam int PREV = tbc_pkg::prev_ch(g);
		logic        clk_tick;
		logic        ev_tick;
		logic        src_tick;
		logic        meas;
		logic        m_edge;
		logic        ovf_evt;
		logic        cnt_wr;
		logic        md_wr;
		logic [15:0] wv;
		logic [15:0] mv;

		assign cnt_wr = wr_en && (wb_adr_i == tbc_pkg::ch_md_adr(g) + tbc_pkg::CH_CNT_OFS);
		assign md_wr  = wr_en && (wb_adr_i == tbc_pkg::ch_md_adr(g));
		assign wv     = lane16(rel_r[g], wb_dat_i, wb_sel_i);
		assign mv     = lane16({6'h00, mode_r[g]}, wb_dat_i, wb_sel_i);
		assign meas   = (mode_r[g][1:0] == tbc_pkg::TBC_MODE_MEASURE);

		always_comb begin
			unique case (mode_r[g][tbc_pkg::MD_CLK_LSB +: 2])
				tbc_pkg::CLK_F1:   clk_tick = tick_bus.f1;
				tbc_pkg::CLK_F8:   clk_tick = tick_bus.f8;
				tbc_pkg::CLK_F2N:  clk_tick = tick_bus.f2n;
				tbc_pkg::CLK_SUBCLOCK_DIV32: clk_tick = tick_bus.subclock_div32;
			endcase
		end

		// Neighbour underflow is registered, which breaks the 0-2-1 ring into a loop-free chain
		assign ev_tick = mode_r[g][tbc_pkg::MD_EVT_SRC] ? uf_r[PREV] :
			tbc_pkg::edge_hit(mode_r[g][tbc_pkg::MD_EDGE_LSB +: 2], rise[g], fall[g]);
		assign src_tick = (mode_r[g][1:0] == tbc_pkg::TBC_MODE_EVENT) ? ev_tick : clk_tick;
		assign m_edge = meas && run_r[g] && tbc_pkg::edge_hit(
			{mode_r[g][tbc_pkg::MD_SEL_HIGH], mode_r[g][tbc_pkg::MD_SEL_LOW]}, rise[g], fall[g]);
		assign ovf_evt = meas && run_r[g] && src_tick && !m_edge && (cnt_r[g] == tbc_pkg::CNT_MAX);
		assign irq_req[g] = irq_r[g];

		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				cnt_r[g] <= tbc_pkg::CNT_RST;
				rel_r[g] <= tbc_pkg::CNT_RST;
				uf_r[g]  <= 1'b0;
				irq_r[g] <= 1'b0;
			end else begin
				uf_r[g]  <= 1'b0;
				irq_r[g] <= 1'b0;
				if (meas) begin
					if (m_edge) begin
						rel_r[g] <= cnt_r[g];
						cnt_r[g] <= tbc_pkg::CNT_ZERO;
						irq_r[g] <= first_r[g];
					end else if (run_r[g] && src_tick) begin
						cnt_r[g] <= cnt_r[g] + 16'h0001;
						irq_r[g] <= ovf_evt;
					end
				end else if (cnt_wr && !run_r[g]) begin
					rel_r[g] <= wv;
					cnt_r[g] <= wv;
				end else begin
					if (cnt_wr) begin
						rel_r[g] <= wv;
					end
					if (run_r[g] && src_tick) begin
						if (cnt_r[g] == tbc_pkg::CNT_ZERO) begin
							cnt_r[g] <= rel_r[g];
							uf_r[g]  <= 1'b1;
							irq_r[g] <= 1'b1;
						end else begin
							cnt_r[g] <= cnt_r[g] - 16'h0001;
						end
					end
				end
			end
		end

		// Result stays unqualified until a second edge; software must discard it
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				first_r[g] <= 1'b0;
			end else if (!run_r[g]) begin
				first_r[g] <= 1'b0;
			end else if (m_edge) begin
				first_r[g] <= 1'b1;
			end
		end

		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				mode_r[g] <= tbc_pkg::MODE_RST;
			end else if (md_wr) begin
				mode_r[g] <= mv[9:0] & ~(10'h001 << tbc_pkg::MD_OVF);
			end
		end

		// Set wins over a clear in the same cycle
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				ovf_r[g]  <= 1'b0;
				ovft_r[g] <= 1'b0;
			end else if (ovf_evt) begin
				ovf_r[g]  <= 1'b1;
				ovft_r[g] <= 1'b0;
			end else if (md_wr && !mv[tbc_pkg::MD_OVF] && run_r[g] && ovft_r[g]) begin
				ovf_r[g]  <= 1'b0;
				ovft_r[g] <= 1'b0;
			end else if (ovf_r[g] && run_r[g] && src_tick) begin
				ovft_r[g] <= 1'b1;
			end
		end

		a_uf_reload: assert property (@(posedge mclk) disable iff (!rst_b)
			(!meas && run_r[g] && src_tick && cnt_r[g] == tbc_pkg::CNT_ZERO && !cnt_wr)
			|=> (cnt_r[g] == $past(rel_r[g])) && uf_r[g] && irq_r[g])
			else $error("underflow did not reload");
		a_down_step: assert property (@(posedge mclk) disable iff (!rst_b)
			(!meas && run_r[g] && src_tick && cnt_r[g] != tbc_pkg::CNT_ZERO)
			|=> cnt_r[g] == $past(cnt_r[g]) - 16'h0001)
			else $error("counter did not step down");
		a_stop_hold: assert property (@(posedge mclk) disable iff (!rst_b)
			(!run_r[g] && !cnt_wr) |=> $stable(cnt_r[g]) && !irq_r[g])
			else $error("stopped counter moved");
		a_stop_write: assert property (@(posedge mclk) disable iff (!rst_b)
			(!meas && !run_r[g] && cnt_wr) |=> (cnt_r[g] == $past(wv)) && (rel_r[g] == $past(wv)))
			else $error("stopped write not loaded");
		a_meas_latch: assert property (@(posedge mclk) disable iff (!rst_b)
			m_edge |=> (rel_r[g] == $past(cnt_r[g])) && (cnt_r[g] == tbc_pkg::CNT_ZERO))
			else $error("edge did not latch count");
		a_meas_up: assert property (@(posedge mclk) disable iff (!rst_b)
			(meas && run_r[g] && src_tick && !m_edge) |=> cnt_r[g] == $past(cnt_r[g]) + 16'h0001)
			else $error("counter did not step up");
		a_first_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
			(m_edge && !first_r[g]) |=> !irq_r[g] ##1 first_r[g] || !run_r[g])
			else $error("first edge raised request");
		a_ovf_set: assert property (@(posedge mclk) disable iff (!rst_b)
			ovf_evt |=> ovf_r[g] && irq_r[g] && cnt_r[g] == tbc_pkg::CNT_ZERO)
			else $error("overflow not flagged");
		a_ovf_only_hw: assert property (@(posedge mclk) disable iff (!rst_b)
			(!ovf_r[g] && !ovf_evt) |=> !ovf_r[g])
			else $error("flag set without overflow");
		a_meas_nowrite: assert property (@(posedge mclk) disable iff (!rst_b)
			(meas && cnt_wr && !m_edge && !(run_r[g] && src_tick)) |=> $stable(rel_r[g])
			&& $stable(cnt_r[g]))
			else $error("write changed measurement");
	end
endmodule : tbc_top

// *** verif/tbc_pulse_src.sv ***
// Far-side model: square-wave pulse source on the pins and the subclock tick
`timescale 1ns/10ps
module tbc_pulse_src (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        run,
	input  wire logic [15:0] half,
	output logic      [5:0]  pins,
	output logic             fc_tick
);
	logic [15:0] cnt_r;
	logic [1:0]  sub_r;

	// Pin set-up after the unlock is software's duty, nothing to drive here
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b || !run) begin
			cnt_r <= 16'h0000;
			pins  <= 6'h00;
		end else if (cnt_r == half - 16'h0001) begin
			cnt_r <= 16'h0000;
			pins  <= ~pins;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	// Tick every fourth cycle keeps the subclock source short
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sub_r   <= 2'h0;
			fc_tick <= 1'h0;
		end else begin
			sub_r   <= sub_r + 2'h1;
			fc_tick <= (sub_r == 2'h3);
		end
	end
endmodule : tbc_pulse_src

// *** verif/tbc_top_tb.sv ***
// Self-checking bench for the six-channel timer block
`timescale 1ns/10ps
module tbc_top_tb;
	logic        mclk;
	logic        rst_b;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [5:0]  pins;
	logic        fc_tick;
	logic [5:0]  irq_req;
	logic        src_run;
	logic [15:0] src_half;
	logic [31:0] rd;
	int          n_errors;
	int          samples_checked;
	int          g;

	tbc_top tbc_top_inst (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.channel_input_pin(pins), .fc_tick(fc_tick), .irq_req(irq_req));
	tbc_pulse_src tbc_pulse_src_inst (.mclk(mclk), .rst_b(rst_b), .run(src_run),
		.half(src_half), .pins(pins), .fc_tick(fc_tick));

	initial begin
		mclk = 1'h0;
		forever #5 mclk = ~mclk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Holds the request until ack is sampled; read data is taken at that same edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int t = 0;
		@(posedge mclk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge mclk);
			t++;
		end while (wb_ack_o !== 1'h1 && t < 50);
		rd = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		check("ack", 32'(t < 50), 32'h1);
	endtask : wb

	// Cycles between two successive interrupt pulses of one channel
	task automatic irq_gap(input int ch);
		int t = 0;
		while (irq_req[ch] !== 1'h1 && t < 2000) begin
			@(posedge mclk);
			t++;
		end
		@(posedge mclk);
		g = 1;
		while (irq_req[ch] !== 1'h1 && g < 2000) begin
			@(posedge mclk);
			g++;
		end
	endtask : irq_gap

	task automatic t_reset();
		wb(1'h0, 8'h10, 32'h0);
		check("mode_rst", rd, 32'h0);
		wb(1'h0, 8'h14, 32'h0);
		check("cnt_rst", rd, 32'h0);
		wb(1'h0, 8'h0C, 32'h0);
		check("pins_idle", rd, 32'h0);
		wb(1'h1, 8'h80, 32'hFFFF);
		wb(1'h0, 8'h80, 32'h0);
		check("unmapped", rd, 32'h0);
		$display("end of reset test");
	endtask : t_reset

	task automatic t_interval();
		logic [31:0] a;
		wb(1'h1, 8'h14, 32'h2);
		wb(1'h0, 8'h14, 32'h0);
		check("stopped_write", rd, 32'h2);
		wb(1'h1, 8'h00, 32'h1);
		irq_gap(0);
		check("period_3", 32'(g), 32'h3);
		wb(1'h1, 8'h14, 32'h4);
		wb(1'h0, 8'h14, 32'h0);
		check("live_cnt", 32'(rd < 3), 32'h1);
		irq_gap(0);
		check("period_5", 32'(g), 32'h5);
		wb(1'h1, 8'h18, 32'h21);
		wb(1'h1, 8'h1C, 32'h1);
		wb(1'h1, 8'h00, 32'h3);
		irq_gap(1);
		check("chain", 32'(g), 32'hA);
		wb(1'h1, 8'h00, 32'h0);
		wb(1'h0, 8'h14, 32'h0);
		a = rd;
		repeat (10) @(posedge mclk);
		wb(1'h0, 8'h14, 32'h0);
		check("halted", rd, a);
		$display("end of interval test");
	endtask : t_interval

	task automatic t_event_pin();
		src_half <= 16'h6;
		wb(1'h1, 8'h34, 32'h0);
		wb(1'h1, 8'h30, 32'h101);
		wb(1'h1, 8'h04, 32'h2);
		src_run <= 1'h1;
		irq_gap(4);
		check("rise", 32'(g), 32'hC);
		wb(1'h1, 8'h30, 32'h201);
		irq_gap(4);
		irq_gap(4);
		check("both", 32'(g), 32'h6);
		src_run <= 1'h0;
		wb(1'h1, 8'h04, 32'h0);
		$display("end of event test");
	endtask : t_event_pin

	task automatic t_sources();
		int exp [4] = '{2, 16, 8, 256};
		wb(1'h1, 8'h08, 32'h2);
		wb(1'h1, 8'h3C, 32'h1);
		wb(1'h1, 8'h04, 32'h4);
		for (int k = 0; k < 4; k++) begin
			wb(1'h1, 8'h38, 32'(k << 6));
			irq_gap(5);
			irq_gap(5);
			check("source", 32'(g), 32'(exp[k]));
		end
		wb(1'h1, 8'h04, 32'h0);
		$display("end of source test");
	endtask : t_sources

	task automatic t_measure();
		logic [31:0] md [3] = '{32'h6, 32'h2, 32'hA};
		logic [31:0] ex [3] = '{32'h13, 32'h13, 32'h9};
		int n = 0;
		src_half <= 16'hA;
		wb(1'h1, 8'h20, 32'h6);
		wb(1'h1, 8'h00, 32'h4);
		src_run <= 1'h1;
		repeat (62) begin
			@(posedge mclk);
			n += int'(irq_req[2] === 1'h1);
		end
		check("first_edge", 32'(n), 32'h2);
		for (int k = 0; k < 3; k++) begin
			wb(1'h1, 8'h20, md[k]);
			repeat (45) @(posedge mclk);
			wb(1'h1, 8'h24, 32'hABCD);
			wb(1'h0, 8'h24, 32'h0);
			check("measured", rd, ex[k]);
		end
		src_run <= 1'h0;
		wb(1'h1, 8'h00, 32'h0);
		$display("end of measure test");
	endtask : t_measure

	task automatic t_overflow();
		int t = 0;
		wb(1'h1, 8'h28, 32'h2);
		wb(1'h1, 8'h04, 32'h1);
		while (irq_req[3] !== 1'h1 && t < 70000) begin
			@(posedge mclk);
			t++;
		end
		check("ovf_irq", 32'(t > 65000 && t < 70000), 32'h1);
		wb(1'h0, 8'h28, 32'h0);
		check("ovf_set", 32'(rd[4]), 32'h1);
		wb(1'h1, 8'h04, 32'h0);
		wb(1'h1, 8'h28, 32'h2);
		wb(1'h0, 8'h28, 32'h0);
		check("ovf_kept_stopped", 32'(rd[4]), 32'h1);
		wb(1'h1, 8'h04, 32'h1);
		wb(1'h1, 8'h28, 32'h2);
		wb(1'h0, 8'h28, 32'h0);
		check("ovf_clear", 32'(rd[4]), 32'h0);
		wb(1'h1, 8'h28, 32'h12);
		wb(1'h0, 8'h28, 32'h0);
		check("ovf_no_set", 32'(rd[4]), 32'h0);
		$display("end of overflow test");
	endtask : t_overflow

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	// Longest scenario is the 65536-tick overflow; the rest adds a few thousand
	initial begin
		repeat (90000) @(posedge mclk);
		n_errors++;
		tally_and_finish();
	end

	initial begin
		rst_b    = 1'h0;
		wb_cyc_i = 1'h0;
		wb_stb_i = 1'h0;
		wb_we_i  = 1'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		src_run  = 1'h0;
		src_half = 16'h6;
		n_errors = 0;
		samples_checked = 0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'h1;
		t_reset();
		t_interval();
		t_event_pin();
		t_sources();
		t_measure();
		t_overflow();
		tally_and_finish();
	end
endmodule : tbc_top_tb
